// *** inc/ser_pkg.sv ***
// Package for the status event reporting block: register map, field
// layouts, preset values and carrier types.
// Assumes an APB master on MCLK_I with 32-bit data and word-aligned byte addresses.
`default_nettype none
package ser_pkg;
  localparam int          STAT_W       = 15;
  localparam int          ERR_W        = 16;
  localparam int          ERR_DEPTH    = 8;
  localparam int          ERR_AW       = 3;
  localparam logic [14:0] PTR_PRESET   = 15'h7fff;
  localparam logic [14:0] NTR_PRESET   = 15'h0000;
  localparam logic [14:0] ENAB_PRESET  = 15'h0000;
  localparam int          QUES_ADJ_BIT = 0;
  // Byte offsets
  localparam logic [7:0] OFS_OPER_COND = 8'h00;
  localparam logic [7:0] OFS_OPER_EVNT = 8'h04;
  localparam logic [7:0] OFS_OPER_ENAB = 8'h08;
  localparam logic [7:0] OFS_OPER_PTR  = 8'h0c;
  localparam logic [7:0] OFS_OPER_NTR  = 8'h10;
  localparam logic [7:0] OFS_QUES_COND = 8'h14;
  localparam logic [7:0] OFS_QUES_EVNT = 8'h18;
  localparam logic [7:0] OFS_QUES_ENAB = 8'h1c;
  localparam logic [7:0] OFS_QUES_PTR  = 8'h20;
  localparam logic [7:0] OFS_QUES_NTR  = 8'h24;
  localparam logic [7:0] OFS_PRESET    = 8'h28;
  localparam logic [7:0] OFS_QUEUE     = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h34;
  localparam logic [7:0] OFS_ERR_PUSH  = 8'h38;
  localparam logic [7:0] OFS_ERR_CNT   = 8'h3c;
  // Interrupt status bits
  localparam int IRQ_OPER_SUM = 0;
  localparam int IRQ_QUES_SUM = 1;
  localparam int IRQ_ERR_NEW  = 2;
  localparam int IRQ_ERR_OVF  = 3;
  localparam int IRQ_W        = 4;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  typedef struct packed {
    logic [14:0] ptr;
    logic [14:0] ntr;
    logic [14:0] enab;
  } ser_mask_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ser_apb_req_t;
endpackage : ser_pkg
`default_nettype wire

// *** core/ser_errq.sv ***
// Error queue: signed codes, oldest first, zero when empty.
// Assumes push and pop come from logic on the same clock.
`default_nettype none
module ser_errq (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       push_i,
  input  wire logic signed [15:0]         code_i,
  input  wire logic                       pop_i,
  output logic signed [15:0]              head_o,
  output logic [3:0]                      count_o,
  output logic                            ovf_o
);
  import ser_pkg::*;
  logic signed [15:0] mem [ERR_DEPTH];
  logic [2:0]         rd_reg;
  logic [2:0]         wr_reg;
  logic [3:0]         cnt_reg;
  logic               do_push;
  logic               do_pop;

  assign do_pop  = pop_i && (cnt_reg != 4'h0);
  // Full queue drops newest entry, oldest errors are kept
  assign do_push = push_i && ((cnt_reg != 4'h8) || do_pop);
  assign ovf_o   = push_i && !do_push;
  assign head_o  = (cnt_reg == 4'h0) ? 16'sh0000 : mem[rd_reg];
  assign count_o = cnt_reg;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_reg] <= code_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_reg  <= 3'h0;
      wr_reg  <= 3'h0;
      cnt_reg <= 4'h0;
    end else begin
      if (do_push) wr_reg <= wr_reg + 3'h1;
      if (do_pop) rd_reg <= rd_reg + 3'h1;
      cnt_reg <= cnt_reg + {3'h0, do_push} - {3'h0, do_pop};
    end
  end
endmodule : ser_errq
`default_nettype wire

// *** core/ser_status.sv ***
// Status event reporting: operation and questionable groups, error
// queue, APB slave and one level interrupt.
// Assumes condition inputs come from other clock domains or pins.
//
// Register access over APB and the register addresses were chosen for this implementation.
`default_nettype none
module ser_status (
  input  wire logic                MCLK_I,
  input  wire logic                RST_I,
  input  wire logic                PSEL_I,
  input  wire logic                PENABLE_I,
  input  wire logic                PWRITE_I,
  input  wire logic [7:0]          PADDR_I,
  input  wire logic [31:0]         PWDATA_I,
  output logic [31:0]              PRDATA_O,
  output logic                     PREADY_O,
  output logic                     PSLVERR_O,
  input  wire logic [14:0]         OPER_COND_I,
  input  wire logic [14:0]         QUES_COND_I,
  input  wire logic                ERR_PUSH_I,
  input  wire logic signed [15:0]  ERR_CODE_I,
  input  wire logic                INST_RESET_I,
  output logic                     OPER_SUM_O,
  output logic                     QUES_SUM_O,
  output logic                     IRQ_O
);
  import ser_pkg::*;

  // Synchronised condition inputs, two stages each
  logic [14:0] oper_s1_reg;
  logic [14:0] oper_s2_reg;
  logic [14:0] ques_s1_reg;
  logic [14:0] ques_s2_reg;
  logic [14:0] oper_prev_reg;
  logic [14:0] ques_prev_reg;
  logic [14:0] oper_evnt_reg;
  logic [14:0] ques_evnt_reg;
  logic [14:0] oper_evnt_next;
  logic [14:0] ques_evnt_next;
  ser_mask_t   oper_mask_reg;
  ser_mask_t   ques_mask_reg;
  logic [3:0]  irq_stat_reg;
  logic [3:0]  irq_mask_reg;
  logic [3:0]  irq_set;
  logic        oper_sum_prev_reg;
  logic        ques_sum_prev_reg;
  logic        err_push_s1_reg;
  logic        err_push_s2_reg;
  logic        err_push_d_reg;
  logic        err_push_pulse;
  logic [14:0] oper_hit;
  logic [14:0] ques_hit;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        q_pop;
  logic signed [15:0] q_head;
  logic [3:0]  q_count;
  logic        q_ovf;
  ser_apb_req_t req;

  assign req = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I,
                 paddr: PADDR_I, pwdata: PWDATA_I};
  // Slave answers in the first access cycle, so every access is two cycles
  assign wr_en = req.psel && req.penable && req.pwrite && PREADY_O;
  assign rd_en = req.psel && req.penable && !req.pwrite && PREADY_O;

  always_comb begin
    case (req.paddr)
      OFS_OPER_COND, OFS_OPER_EVNT, OFS_OPER_ENAB, OFS_OPER_PTR,
      OFS_OPER_NTR, OFS_QUES_COND, OFS_QUES_EVNT, OFS_QUES_ENAB,
      OFS_QUES_PTR, OFS_QUES_NTR, OFS_PRESET, OFS_QUEUE,
      OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_ERR_PUSH, OFS_ERR_CNT:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  assign q_pop = rd_en && addr_ok && (req.paddr == OFS_QUEUE);

  // Condition synchronisers; INST_RESET_I touches none of the status parts
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      oper_s1_reg   <= 15'h0000;
      oper_s2_reg   <= 15'h0000;
      ques_s1_reg   <= 15'h0000;
      ques_s2_reg   <= 15'h0000;
      oper_prev_reg <= 15'h0000;
      ques_prev_reg <= 15'h0000;
    end else begin
      oper_s1_reg   <= OPER_COND_I;
      oper_s2_reg   <= oper_s1_reg;
      ques_s1_reg   <= QUES_COND_I;
      ques_s2_reg   <= ques_s1_reg;
      oper_prev_reg <= oper_s2_reg;
      ques_prev_reg <= ques_s2_reg;
    end
  end

  // Per-bit transition filters
  genvar gi;
  generate
    for (gi = 0; gi < STAT_W; gi++) begin : g_filt
      assign oper_hit[gi] =
        (oper_mask_reg.ptr[gi] && oper_s2_reg[gi] && !oper_prev_reg[gi]) ||
        (oper_mask_reg.ntr[gi] && !oper_s2_reg[gi] && oper_prev_reg[gi]);
      assign ques_hit[gi] =
        (ques_mask_reg.ptr[gi] && ques_s2_reg[gi] && !ques_prev_reg[gi]) ||
        (ques_mask_reg.ntr[gi] && !ques_s2_reg[gi] && ques_prev_reg[gi]);
    end
  endgenerate
  // Above: rising filter falling filter

  // Clear on read, but a new hit in the same cycle survives
  always_comb begin
    oper_evnt_next = oper_evnt_reg;
    ques_evnt_next = ques_evnt_reg;
    if (rd_en && req.paddr == OFS_OPER_EVNT) begin
      oper_evnt_next = 15'h0000;
    end
    if (rd_en && req.paddr == OFS_QUES_EVNT) begin
      ques_evnt_next = 15'h0000;
    end
    oper_evnt_next = oper_evnt_next | oper_hit;
    ques_evnt_next = ques_evnt_next | ques_hit;
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      oper_evnt_reg <= 15'h0000;
      ques_evnt_reg <= 15'h0000;
    end else begin
      oper_evnt_reg <= oper_evnt_next;
      ques_evnt_reg <= ques_evnt_next;
    end
  end

  // Masks: written by software, preset loads defaults
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      oper_mask_reg <= '{ptr: PTR_PRESET, ntr: NTR_PRESET,
                         enab: ENAB_PRESET};
      ques_mask_reg <= '{ptr: PTR_PRESET, ntr: NTR_PRESET,
                         enab: ENAB_PRESET};
    end else if (wr_en) begin
      case (req.paddr)
        OFS_OPER_ENAB: oper_mask_reg.enab <= req.pwdata[14:0];
        OFS_OPER_PTR:  oper_mask_reg.ptr  <= req.pwdata[14:0];
        OFS_OPER_NTR:  oper_mask_reg.ntr  <= req.pwdata[14:0];
        OFS_QUES_ENAB: ques_mask_reg.enab <= req.pwdata[14:0];
        OFS_QUES_PTR:  ques_mask_reg.ptr  <= req.pwdata[14:0];
        OFS_QUES_NTR:  ques_mask_reg.ntr  <= req.pwdata[14:0];
        OFS_PRESET: begin
          oper_mask_reg.ptr  <= PTR_PRESET;
          ques_mask_reg.ptr  <= PTR_PRESET;
          oper_mask_reg.ntr  <= NTR_PRESET;
          ques_mask_reg.ntr  <= NTR_PRESET;
          oper_mask_reg.enab <= ENAB_PRESET;
          ques_mask_reg.enab <= ENAB_PRESET;
        end
        default: ;
      endcase
    end
  end

  // Summary outputs, recomputed every cycle
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      OPER_SUM_O        <= 1'b0;
      QUES_SUM_O        <= 1'b0;
      oper_sum_prev_reg <= 1'b0;
      ques_sum_prev_reg <= 1'b0;
    end else begin
      OPER_SUM_O        <= |(oper_evnt_reg & oper_mask_reg.enab);
      QUES_SUM_O        <= |(ques_evnt_reg & ques_mask_reg.enab);
      oper_sum_prev_reg <= OPER_SUM_O;
      ques_sum_prev_reg <= QUES_SUM_O;
    end
  end

  // Error push input is a pin: synchronise, then edge detect
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      err_push_s1_reg <= 1'b0;
      err_push_s2_reg <= 1'b0;
      err_push_d_reg  <= 1'b0;
    end else begin
      err_push_s1_reg <= ERR_PUSH_I;
      err_push_s2_reg <= err_push_s1_reg;
      err_push_d_reg  <= err_push_s2_reg;
    end
  end
  assign err_push_pulse = err_push_s2_reg && !err_push_d_reg;

  // Code must be steady while the push level is high
  ser_errq u_errq (
    .clk_i   (MCLK_I),
    .rst_i   (RST_I),
    .push_i  (err_push_pulse),
    .code_i  (ERR_CODE_I),
    .pop_i   (q_pop),
    .head_o  (q_head),
    .count_o (q_count),
    .ovf_o   (q_ovf)
  );

  // Interrupts: summary rising edges, new error, queue overflow
  assign irq_set[IRQ_OPER_SUM] = OPER_SUM_O && !oper_sum_prev_reg;
  assign irq_set[IRQ_QUES_SUM] = QUES_SUM_O && !ques_sum_prev_reg;
  assign irq_set[IRQ_ERR_NEW]  = err_push_pulse;
  assign irq_set[IRQ_ERR_OVF]  = q_ovf;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= IRQ_MASK_RST;
      IRQ_O        <= 1'b0;
    end else begin
      if (wr_en && req.paddr == OFS_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~req.pwdata[3:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr_en && req.paddr == OFS_IRQ_MASK) begin
        irq_mask_reg <= req.pwdata[3:0];
      end
      IRQ_O <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // APB answer: ready one cycle after setup, data registered then
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      PREADY_O  <= req.psel && !req.penable;
      PSLVERR_O <= req.psel && !req.penable && !addr_ok;
      PRDATA_O  <= 32'h0000_0000;
      if (req.psel && !req.penable && !req.pwrite) begin
        case (req.paddr)
          OFS_OPER_COND: PRDATA_O <= {17'h0, oper_s2_reg};
          OFS_QUES_COND: PRDATA_O <= {17'h0, ques_s2_reg};
          OFS_OPER_EVNT: PRDATA_O <= {17'h0, oper_evnt_next};
          OFS_QUES_EVNT: PRDATA_O <= {17'h0, ques_evnt_next};
          OFS_OPER_ENAB: PRDATA_O <= {17'h0, oper_mask_reg.enab};
          OFS_OPER_PTR:  PRDATA_O <= {17'h0, oper_mask_reg.ptr};
          OFS_OPER_NTR:  PRDATA_O <= {17'h0, oper_mask_reg.ntr};
          OFS_QUES_ENAB: PRDATA_O <= {17'h0, ques_mask_reg.enab};
          OFS_QUES_PTR:  PRDATA_O <= {17'h0, ques_mask_reg.ptr};
          OFS_QUES_NTR:  PRDATA_O <= {17'h0, ques_mask_reg.ntr};
          OFS_QUEUE:     PRDATA_O <= {{16{q_head[15]}}, q_head};
          OFS_IRQ_STAT:  PRDATA_O <= {28'h0, irq_stat_reg};
          OFS_IRQ_MASK:  PRDATA_O <= {28'h0, irq_mask_reg};
          OFS_ERR_CNT:   PRDATA_O <= {28'h0, q_count};
          default:       PRDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : ser_status
`default_nettype wire

// *** dv/ser_status_properties.sv ***
// Checker for the status event reporting block, bound to ser_status.
// Assumes an APB master that holds its request until PREADY_O.
`default_nettype none
module ser_status_properties
  import ser_pkg::*;
(
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        OPER_SUM_O,
  input wire logic        QUES_SUM_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  logic wr_done;
  assign wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  setup_answer_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no answer one cycle after setup");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held longer than one cycle");
  ready_access_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("ready outside an access phase");
  unmapped_err_a: assert property (PREADY_O &&
    (PADDR_I > OFS_ERR_CNT || PADDR_I[1:0] != 2'b00)
    |-> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (PREADY_O && PADDR_I <= OFS_ERR_CNT &&
    PADDR_I[1:0] == 2'b00 |-> !PSLVERR_O)
    else $error("mapped access refused");
  part_width_a: assert property (PREADY_O && !PWRITE_I &&
    PADDR_I <= OFS_QUES_NTR |-> PRDATA_O[31:15] == 17'h0)
    else $error("status part wider than 15 bits");
  code_sign_a: assert property (PREADY_O && !PWRITE_I &&
    PADDR_I == OFS_QUEUE |-> PRDATA_O[31:16] == {16{PRDATA_O[15]}})
    else $error("queue code not sign extended");
  preset_sum_a: assert property (wr_done &&
    PADDR_I == OFS_PRESET |-> ##[1:2] !OPER_SUM_O && !QUES_SUM_O)
    else $error("summary survives preset");
  enab_gate_a: assert property (wr_done && PADDR_I == OFS_OPER_ENAB &&
    PWDATA_I[14:0] == 15'h0 |-> ##[1:2] !OPER_SUM_O)
    else $error("summary without enable");
  cover property ($rose(OPER_SUM_O));
  cover property ($rose(QUES_SUM_O));
  cover property (PREADY_O && PSLVERR_O);
endmodule : ser_status_properties
bind ser_status ser_status_properties chk_u (
  .MCLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
  .PRDATA_O, .PREADY_O, .PSLVERR_O, .OPER_SUM_O, .QUES_SUM_O
);
`default_nettype wire

// *** dv/ser_host.sv ***
// Remote host model: APB master that issues status queries.
// Assumes xfer is called just after a rising clock edge.
`default_nettype none
module ser_host (
  input  wire logic              clk_i,
  input  wire logic [31:0]       prdata_i,
  input  wire logic              pready_i,
  input  wire logic              pslverr_i,
  output var ser_pkg::ser_apb_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ser_pkg::*;
  initial req_o = '0;
  // Unbounded wait; the bench timeout cuts a hang short
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    req_o <= '{1'b1, 1'b0, wr, a, {17'h0, d[14:0]}};
    @(posedge clk_i);
    req_o.penable <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    req_o <= '0;
    @(posedge clk_i);
  endtask : xfer
endmodule : ser_host
`default_nettype wire

// *** dv/ser_status_tb.sv ***
// Testbench for the status event reporting block.
// Assumes the host model and the bound checker are compiled first.
`default_nettype none
module ser_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ser_pkg::*;
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  logic [14:0]        oper_cond = '0;
  logic [14:0]        ques_cond = '0;
  logic               err_push = 1'b0;
  logic signed [15:0] err_code = '0;
  logic               inst_rst = 1'b0;
  logic [31:0]        prdata;
  logic               pready, pslverr, oper_sum, ques_sum, irq;
  ser_apb_req_t       req;
  int                 fail_count = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  always #4ns mclk = ~mclk;
  ser_status dut_u (.MCLK_I(mclk), .RST_I(rst), .PSEL_I(req.psel),
    .PENABLE_I(req.penable), .PWRITE_I(req.pwrite), .PADDR_I(req.paddr),
    .PWDATA_I(req.pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .OPER_COND_I(oper_cond), .QUES_COND_I(ques_cond),
    .ERR_PUSH_I(err_push), .ERR_CODE_I(err_code), .INST_RESET_I(inst_rst),
    .OPER_SUM_O(oper_sum), .QUES_SUM_O(ques_sum), .IRQ_O(irq));
  ser_host host_u (.clk_i(mclk), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .req_o(req));
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Whole run is about 290 cycles; the ceiling leaves ample slack
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp32
  task automatic cmp1(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask : cmp1
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host_u.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    host_u.xfer(1'b0, a, 32'h0, q, e);
    cmp32(q, exp);
    cmp1(e, a > OFS_ERR_CNT);
  endtask : rd
  task automatic setc(input logic [14:0] v);
    oper_cond <= v;
    ques_cond <= v;
    tick(8);
  endtask : setc
  task automatic push(input logic signed [15:0] c);
    err_code <= c;
    err_push <= 1'b1;
    tick(3);
    err_push <= 1'b0;
    tick(3);
  endtask : push
  task automatic chk_masks();
    for (int g = 0; g < 2; g++) begin
      rd(OFS_OPER_PTR + 8'(g * 20), 32'h7fff);
      rd(OFS_OPER_NTR + 8'(g * 20), 32'h0);
      rd(OFS_OPER_ENAB + 8'(g * 20), 32'h0);
    end
  endtask : chk_masks
  initial begin
    tick(16);
    rst <= 1'b0;
    tick(1);
    chk_masks();
    rd(OFS_QUEUE, 32'h0);
    rd(8'h40, 32'h0);
    rd(OFS_ERR_PUSH, 32'h0);
    for (int g = 0; g < 2; g++) begin
      wr(OFS_OPER_PTR + 8'(g * 20), 32'hffff_c001);
      wr(OFS_OPER_NTR + 8'(g * 20), 32'h2);
    end
    inst_rst <= 1'b1;
    tick(2);
    inst_rst <= 1'b0;
    setc(15'h4003);
    for (int g = 0; g < 2; g++) begin
      rd(OFS_OPER_PTR + 8'(g * 20), 32'h4001);
      rd(OFS_OPER_COND + 8'(g * 20), 32'h4003);
      rd(OFS_OPER_COND + 8'(g * 20), 32'h4003);
      rd(OFS_OPER_EVNT + 8'(g * 20), 32'h4001);
      rd(OFS_OPER_EVNT + 8'(g * 20), 32'h0);
    end
    setc(15'h4001);
    for (int g = 0; g < 2; g++) begin
      rd(OFS_OPER_EVNT + 8'(g * 20), 32'h2);
    end
    // Bits 14 and 0 fall with their falling filter clear
    setc(15'h0000);
    for (int g = 0; g < 2; g++) begin
      rd(OFS_OPER_EVNT + 8'(g * 20), 32'h0);
    end
    wr(OFS_QUES_ENAB, 32'h1);
    wr(OFS_IRQ_MASK, 32'h3);
    setc(15'h0001);
    cmp1(ques_sum, 1'b1);
    cmp1(oper_sum, 1'b0);
    cmp1(irq, 1'b1);
    rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_STAT, 32'h2);
    tick(3);
    cmp1(irq, 1'b0);
    wr(OFS_OPER_ENAB, 32'h1);
    tick(4);
    cmp1(oper_sum, 1'b1);
    cmp1(irq, 1'b1);
    wr(OFS_OPER_ENAB, 32'h0);
    tick(3);
    cmp1(oper_sum, 1'b0);
    rd(OFS_QUES_EVNT, 32'h1);
    tick(3);
    cmp1(ques_sum, 1'b0);
    wr(OFS_OPER_ENAB, 32'h1);
    wr(OFS_PRESET, 32'h0);
    tick(3);
    cmp1(oper_sum, 1'b0);
    chk_masks();
    push(16'shfffb);
    push(16'sh0007);
    rd(OFS_ERR_CNT, 32'h2);
    rd(OFS_QUEUE, 32'hffff_fffb);
    rd(OFS_QUEUE, 32'h7);
    rd(OFS_QUEUE, 32'h0);
    // Bit 1 rises so that its hit lands on the clearing edge of the read
    oper_cond <= 15'h0003;
    ques_cond <= 15'h0003;
    tick(1);
    rd(OFS_OPER_EVNT, 32'h1);
    rd(OFS_OPER_EVNT, 32'h2);
    rd(OFS_QUES_EVNT, 32'h2);
    // Nine pushes into eight entries: newest dropped, overflow flagged
    for (int i = 1; i < 10; i++) begin
      push(16'(i));
    end
    rd(OFS_ERR_CNT, 32'h8);
    rd(OFS_IRQ_STAT, 32'hd);
    rd(OFS_QUEUE, 32'h1);
    finish_test();
  end
endmodule : ser_status_tb
`default_nettype wire
